// File: common/adop_pkg.sv
package adop_pkg;
  typedef enum logic [2:0] {
    ADOP_PAT_NONE   = 3'b000,
    ADOP_PAT_SYNC   = 3'b001,
    ADOP_PAT_DESKEW = 3'b010,
    ADOP_PAT_CUSTOM = 3'b011,
    ADOP_PAT_ONES   = 3'b100,
    ADOP_PAT_TOGGLE = 3'b101,
    ADOP_PAT_ZEROS  = 3'b110,
    ADOP_PAT_RAMP   = 3'b111
  } adop_pattern_t;

  typedef struct packed {
    logic [1:0]        sclk_sync;
    logic [1:0]        sen_sync;
    logic [1:0]        sdat_sync;
    logic              sclk_last;
    logic [23:0]       cfg_shift;
    logic [4:0]        cfg_count;
    logic [15:0]       noise_and_lane_rate_control;
    logic [15:0]       averaging_and_pattern_select;
    logic [15:0]       offset_gain_rate_control;
    logic [15:0]       output_coding_control;
    logic [15:0]       custom_pattern_value;
    logic [15:0]       pattern_sync_control;
    logic [15:0]       hpf_control_low_group;
    logic [15:0]       hpf_control_high_group;
    logic [7:0][15:0]  chan_reg;
    logic [7:0][17:0]  hpf_x;
    logic [7:0][17:0]  hpf_y;
    logic [13:0]       ramp;
    logic              toggle;
    logic              chop;
    logic [7:0][27:0]  bank;
    logic              bank_2x;
    logic              req;
    logic [1:0]        ack_sync;
  } adop_core_t;

  typedef struct packed {
    logic [1:0]        req_sync;
    logic              req_seen;
    logic [7:0][27:0]  shift;
    logic [3:0]        count;
    logic              two_x;
    logic              start;
    logic              ack;
  } adop_link_t;
endpackage

// File: common/adop_regs.svh
`ifndef ADOP_REGS_SVH
`define ADOP_REGS_SVH
`define ADOP_ADDR_NOISE_LANE 8'h01
`define ADOP_ADDR_AVG_PAT    8'h02
`define ADOP_ADDR_OFFS_GAIN  8'h03
`define ADOP_ADDR_CODING     8'h04
`define ADOP_ADDR_CUSTOM     8'h05
`define ADOP_ADDR_PAT_SYNC   8'h0a
`define ADOP_ADDR_HPF_LO     8'h15
`define ADOP_ADDR_HPF_HI     8'h21
`define ADOP_ADDR_CH1        8'h0d
`define ADOP_ADDR_CH2        8'h0f
`define ADOP_ADDR_CH3        8'h11
`define ADOP_ADDR_CH4        8'h13
`define ADOP_ADDR_CH5        8'h1f
`define ADOP_ADDR_CH6        8'h1d
`define ADOP_ADDR_CH7        8'h1b
`define ADOP_ADDR_CH8        8'h19
`define ADOP_BIT_NOISE_SUP   11
`define ADOP_BIT_LANE_2X     14
`define ADOP_BIT_AVERAGE     11
`define ADOP_PAT_HI          15
`define ADOP_PAT_LO          13
`define ADOP_BIT_OFFS_EN     8
`define ADOP_BIT_GAIN_EN     12
`define ADOP_BIT_CODING      3
`define ADOP_BIT_PAT_SYNC    8
`define ADOP_BIT_HPF_EN      0
`define ADOP_HPF_K_HI        4
`define ADOP_HPF_K_LO        1
`define ADOP_OFFS_HI         9
`define ADOP_GAIN_HI         15
`define ADOP_GAIN_LO         11
`define ADOP_CUSTOM_HI       13
`define ADOP_REG_RESET       16'h0000
`define ADOP_DESKEW_WORD     14'h1555
`define ADOP_SYNC_WORD       14'h3f80
`define ADOP_ONES_WORD       14'h3fff
`define ADOP_GAIN_CODE_MAX   5'h1e
`define ADOP_GAIN_UNITY      14'h1000
`define ADOP_GAIN_FRAC       12
`define ADOP_CFG_LAST_BIT    5'h17
`define ADOP_PAIRS_1X        4'h6
`define ADOP_PAIRS_2X        4'hd
`endif

// File: rtl/adop_core.sv
// Notes on behaviour
// (R1) Averaging bit averages channel pairs 1-2,3-4,5-6,7-8
// (R2) Pair averages go out on lanes 3 to 6
// (R3) Coding bit inverts MSB for offset binary
// (R4) Digital gain is 0.2 dB times code
// (R5) Gain code 31 behaves as code 30
// (R6) Separate filter enables for channels 1-4, 5-8
// (R7) Filter y = 2^k/(2^k+1)(x - xp + yp)
// (R8) Software keeps filter k within 2 to 10
// (R9) Noise suppression chops low-frequency noise to Fs/2
// (R10) Two bits per bit clock, both edges
// (R11) Lane sharing bit packs two ADCs per lane
// (R12) Shared lanes carry lower channel first
// (R13) Unused lanes send zero when sharing
// (R14) Signed 10-bit offset subtracted per channel
// (R15) Offset first, gain last, coding at end
// (R16) Three-bit pattern field replaces ADC data
// (R17) Ramp pattern rises one LSB per sample
// (R18) Codes 110 all zeros, 100 all ones
// (R19) Code 010 sends alternating deskew word
// (R20) Code 001 sends fixed sync word
// (R21) Code 101 toggles all ones and zeros
// (R22) Code 011 sends custom register value
// (R23) Sync bit aligns all channel patterns
`timescale 1ns/1ns
`default_nettype none
`include "adop_regs.svh"
module adop_core (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             lane_bit_clock,
  input  wire logic             adc_sample_valid,
  input  wire logic [7:0][13:0] adc_sample_data,
  input  wire logic             cfg_sclk,
  input  wire logic             cfg_sen_n,
  input  wire logic             cfg_sdata,
  output logic                  sample_busy,
  output logic                  noise_chop_phase,
  output logic [7:0]            lane_rise_bits,
  output logic [7:0]            lane_fall_bits,
  output logic                  lane_word_start
);
  import adop_pkg::*;

  localparam logic [30:0][13:0] ADOP_GAIN_TABLE = {
    14'h1fed, 14'h1f33, 14'h1e7d, 14'h1dcb, 14'h1d1d, 14'h1c74, 14'h1bce, 14'h1b2c,
    14'h1a8e, 14'h19f3, 14'h195c, 14'h18c8, 14'h1838, 14'h17aa, 14'h1721, 14'h169a,
    14'h1616, 14'h1595, 14'h1518, 14'h149d, 14'h1425, 14'h13af, 14'h133c, 14'h12cc,
    14'h125f, 14'h11f4, 14'h118b, 14'h1125, 14'h10c1, 14'h105f, 14'h1000};
  localparam logic [7:0][7:0] ADOP_CH_ADDR = {
    `ADOP_ADDR_CH8, `ADOP_ADDR_CH7, `ADOP_ADDR_CH6, `ADOP_ADDR_CH5,
    `ADOP_ADDR_CH4, `ADOP_ADDR_CH3, `ADOP_ADDR_CH2, `ADOP_ADDR_CH1};

  function automatic logic [13:0] adop_sat14(input logic signed [29:0] v);
    if (v > $signed(30'h00001fff)) begin
      return 14'h1fff;
    end else if (v < $signed(30'h3fffe000)) begin
      return 14'h2000;
    end else begin
      return v[13:0];
    end
  endfunction

  // Codes above 30 clamp to the 6 dB entry
  function automatic logic [13:0] adop_gain_q(input logic [4:0] code);
    if (code > `ADOP_GAIN_CODE_MAX) begin // R5
      return ADOP_GAIN_TABLE[`ADOP_GAIN_CODE_MAX];
    end else begin
      return ADOP_GAIN_TABLE[code]; // R4
    end
  endfunction

  function automatic logic [13:0] adop_code(input logic [13:0] d, input logic obin);
    return {d[13] ^ obin, d[12:0]};
  endfunction

  adop_core_t       st_reg;
  adop_core_t       st_next;
  adop_link_t       lk_reg;
  adop_link_t       lk_next;
  logic             sclk_rise;
  logic             commit;
  logic [23:0]      cfg_word;
  logic             ramp_clear;
  logic             idle;
  logic             load;
  logic             lane2x;
  logic             avg_sel;
  logic             obin;
  adop_pattern_t    pat;
  logic [7:0][13:0] proc;
  logic [3:0][13:0] avg_word;
  logic [7:0][13:0] word;
  logic             new_req;

  always_comb begin
    logic signed [17:0] v;
    logic signed [17:0] a;
    logic signed [17:0] y;
    logic signed [29:0] p;
    logic signed [27:0] num;
    logic signed [27:0] den;
    logic signed [14:0] sum;
    logic [15:0]        hreg;
    logic [13:0]        gq;
    logic [3:0]         k;
    logic [13:0]        dsel;
    logic [13:0]        pw;
    v = 18'h00000;
    a = 18'h00000;
    y = 18'h00000;
    p = 30'h00000000;
    num = 28'h0000000;
    den = 28'h0000000;
    sum = 15'h0000;
    hreg = 16'h0000;
    gq = 14'h0000;
    k = 4'h0;
    dsel = 14'h0000;
    pw = 14'h0000;
    st_next = st_reg;
    st_next.sclk_sync = {st_reg.sclk_sync[0], cfg_sclk};
    st_next.sen_sync = {st_reg.sen_sync[0], cfg_sen_n};
    st_next.sdat_sync = {st_reg.sdat_sync[0], cfg_sdata};
    st_next.sclk_last = st_reg.sclk_sync[1];
    st_next.ack_sync = {st_reg.ack_sync[0], lk_reg.ack};
    sclk_rise = st_reg.sclk_sync[1] & ~st_reg.sclk_last;
    cfg_word = {st_reg.cfg_shift[22:0], st_reg.sdat_sync[1]};
    commit = 1'b0;
    // Serial configuration: 8 address bits then 16 data bits, MSB first
    if (st_reg.sen_sync[1]) begin
      st_next.cfg_count = 5'h00;
    end else if (sclk_rise) begin
      st_next.cfg_shift = cfg_word;
      if (st_reg.cfg_count == `ADOP_CFG_LAST_BIT) begin
        commit = 1'b1; // R22
        st_next.cfg_count = 5'h00;
      end else begin
        st_next.cfg_count = st_reg.cfg_count + 5'h01;
      end
    end
    if (commit) begin
      unique case (cfg_word[23:16])
        `ADOP_ADDR_NOISE_LANE: st_next.noise_and_lane_rate_control = cfg_word[15:0];
        `ADOP_ADDR_AVG_PAT:    st_next.averaging_and_pattern_select = cfg_word[15:0];
        `ADOP_ADDR_OFFS_GAIN:  st_next.offset_gain_rate_control = cfg_word[15:0];
        `ADOP_ADDR_CODING:     st_next.output_coding_control = cfg_word[15:0];
        `ADOP_ADDR_CUSTOM:     st_next.custom_pattern_value = cfg_word[15:0]; // R22
        `ADOP_ADDR_PAT_SYNC:   st_next.pattern_sync_control = cfg_word[15:0];
        `ADOP_ADDR_HPF_LO:     st_next.hpf_control_low_group = cfg_word[15:0]; // R6
        `ADOP_ADDR_HPF_HI:     st_next.hpf_control_high_group = cfg_word[15:0]; // R6
        default: begin
          for (int c = 0; c < 8; c++) begin
            if (cfg_word[23:16] == ADOP_CH_ADDR[c]) begin
              st_next.chan_reg[c] = cfg_word[15:0];
            end
          end
        end
      endcase
    end
    pat = adop_pattern_t'(st_reg.averaging_and_pattern_select[`ADOP_PAT_HI:`ADOP_PAT_LO]); // R16
    lane2x = st_reg.noise_and_lane_rate_control[`ADOP_BIT_LANE_2X]; // R11
    avg_sel = st_reg.averaging_and_pattern_select[`ADOP_BIT_AVERAGE] & ~lane2x; // R1
    obin = st_reg.output_coding_control[`ADOP_BIT_CODING];
    // Offset, filter, gain per channel
    for (int c = 0; c < 8; c++) begin
      hreg = (c < 4) ? st_reg.hpf_control_low_group : st_reg.hpf_control_high_group; // R6
      k = hreg[`ADOP_HPF_K_HI:`ADOP_HPF_K_LO]; // R8
      v = 18'(signed'(adc_sample_data[c]));
      if (st_reg.noise_and_lane_rate_control[`ADOP_BIT_NOISE_SUP] && st_reg.chop) begin
        v = -v; // R9
      end
      if (st_reg.offset_gain_rate_control[`ADOP_BIT_OFFS_EN]) begin
        v = v - 18'(signed'(st_reg.chan_reg[c][`ADOP_OFFS_HI:0])); // R14 R15
      end
      a = v - signed'(st_reg.hpf_x[c]) + signed'(st_reg.hpf_y[c]);
      num = 28'(a) <<< k;
      den = (28'sh0000001 <<< k) + 28'sh0000001;
      y = 18'(num / den); // R7
      if (adc_sample_valid) begin
        st_next.hpf_x[c] = v;
        st_next.hpf_y[c] = y;
      end
      if (hreg[`ADOP_BIT_HPF_EN]) begin
        v = y; // R6
      end
      gq = st_reg.offset_gain_rate_control[`ADOP_BIT_GAIN_EN] ?
           adop_gain_q(st_reg.chan_reg[c][`ADOP_GAIN_HI:`ADOP_GAIN_LO]) : `ADOP_GAIN_UNITY;
      p = 30'(signed'(adop_sat14(30'(v)))) * 30'(signed'({1'b0, gq})); // R4 R15
      proc[c] = adop_sat14(p >>> `ADOP_GAIN_FRAC);
    end
    for (int q = 0; q < 4; q++) begin
      sum = 15'(signed'(proc[2*q])) + 15'(signed'(proc[2*q+1]));
      avg_word[q] = sum[14:1]; // R1
    end
    // Lane words: averaging selection, patterns, coding
    for (int c = 0; c < 8; c++) begin
      dsel = (avg_sel && c >= 2 && c <= 5) ? avg_word[2'(c - 2)] : proc[c]; // R2
      unique case (pat)
        ADOP_PAT_RAMP: begin
          pw = st_reg.pattern_sync_control[`ADOP_BIT_PAT_SYNC] ?
               st_reg.ramp : st_reg.ramp + 14'(c); // R17 R23
        end
        ADOP_PAT_ZEROS:  pw = 14'h0000; // R18
        ADOP_PAT_ONES:   pw = `ADOP_ONES_WORD; // R18
        ADOP_PAT_DESKEW: pw = `ADOP_DESKEW_WORD; // R19
        ADOP_PAT_SYNC:   pw = `ADOP_SYNC_WORD; // R20
        ADOP_PAT_TOGGLE: pw = {14{st_reg.toggle}}; // R21
        ADOP_PAT_CUSTOM: pw = st_reg.custom_pattern_value[`ADOP_CUSTOM_HI:0]; // R22
        ADOP_PAT_NONE:   pw = adop_code(dsel, obin); // R3 R15
      endcase
      word[c] = pw; // R16
    end
    ramp_clear = commit &&
                 ((cfg_word[23:16] == `ADOP_ADDR_PAT_SYNC && cfg_word[`ADOP_BIT_PAT_SYNC]) ||
                  (cfg_word[23:16] == `ADOP_ADDR_AVG_PAT &&
                   st_reg.pattern_sync_control[`ADOP_BIT_PAT_SYNC]));
    if (ramp_clear) begin
      st_next.ramp = 14'h0000; // R23
      st_next.toggle = 1'b0;
    end else if (adc_sample_valid) begin
      st_next.ramp = st_reg.ramp + 14'h0001; // R17
      st_next.toggle = ~st_reg.toggle; // R21
    end
    if (adc_sample_valid) begin
      st_next.chop = ~st_reg.chop; // R9
    end
    idle = (st_reg.req == st_reg.ack_sync[1]);
    load = adc_sample_valid & idle;
    if (load) begin
      for (int c = 0; c < 8; c++) begin
        if (lane2x) begin
          st_next.bank[c] = (c >= 2 && c <= 5) ?
                            {word[3'(2*(c-2))], word[3'(2*(c-2)+1)]} : 28'h0000000; // R12 R13
        end else if (avg_sel && (c < 2 || c > 5)) begin
          st_next.bank[c] = 28'h0000000; // R2
        end else begin
          st_next.bank[c] = {word[c], 14'h0000}; // R11
        end
      end
      st_next.bank_2x = lane2x;
      st_next.req = ~st_reg.req;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Link side: bank words are held stable while a request is pending
  always_comb begin
    lk_next = lk_reg;
    lk_next.req_sync = {lk_reg.req_sync[0], st_reg.req};
    lk_next.start = 1'b0;
    new_req = (lk_reg.req_sync[1] != lk_reg.req_seen);
    if (lk_reg.count == 4'h0 && new_req) begin
      lk_next.shift = st_reg.bank;
      lk_next.two_x = st_reg.bank_2x;
      lk_next.count = st_reg.bank_2x ? `ADOP_PAIRS_2X : `ADOP_PAIRS_1X; // R11
      lk_next.req_seen = lk_reg.req_sync[1];
      lk_next.ack = lk_reg.req_sync[1];
      lk_next.start = 1'b1;
    end else begin
      for (int c = 0; c < 8; c++) begin
        lk_next.shift[c] = {lk_reg.shift[c][25:0], 2'b00}; // R10
      end
      if (lk_reg.count != 4'h0) begin
        lk_next.count = lk_reg.count - 4'h1;
      end
    end
  end

  always_ff @(posedge lane_bit_clock or posedge reset) begin
    if (reset) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      lane_rise_bits[c] = lk_reg.shift[c][27]; // R10
      lane_fall_bits[c] = lk_reg.shift[c][26]; // R10
    end
  end
  assign lane_word_start = lk_reg.start;
  assign sample_busy = ~idle;
  assign noise_chop_phase = st_reg.chop;

  AST_RAMP_STEP: assert property (@(posedge core_clk) disable iff (reset) // R17
    adc_sample_valid && !ramp_clear |=> st_reg.ramp == $past(st_reg.ramp) + 14'h0001)
    else $error("ramp did not step by one");
  AST_SYNC_CLEAR: assert property (@(posedge core_clk) disable iff (reset) // R23
    ramp_clear |=> st_reg.ramp == 14'h0000 && !st_reg.toggle)
    else $error("pattern sync did not restart ramp");
  AST_CUSTOM_WRITE: assert property (@(posedge core_clk) disable iff (reset) // R22
    commit && cfg_word[23:16] == `ADOP_ADDR_CUSTOM
    |=> st_reg.custom_pattern_value == $past(cfg_word[15:0]))
    else $error("custom value not stored");
  AST_ZEROS: assert property (@(posedge core_clk) disable iff (reset) // R18
    load && pat == ADOP_PAT_ZEROS && !lane2x |=> st_reg.bank[3][27:14] == 14'h0000)
    else $error("zeros pattern wrong");
  AST_DESKEW: assert property (@(posedge core_clk) disable iff (reset) // R19
    load && pat == ADOP_PAT_DESKEW && !lane2x |=> st_reg.bank[3][27:14] == `ADOP_DESKEW_WORD)
    else $error("deskew pattern wrong");
  AST_SYNC_WORD: assert property (@(posedge core_clk) disable iff (reset) // R20
    load && pat == ADOP_PAT_SYNC && !lane2x |=> st_reg.bank[3][27:14] == `ADOP_SYNC_WORD)
    else $error("sync pattern wrong");
  AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (reset) // R13
    load && lane2x |=> st_reg.bank[0] == 28'h0000000 && st_reg.bank[1] == 28'h0000000 &&
                       st_reg.bank[6] == 28'h0000000 && st_reg.bank[7] == 28'h0000000)
    else $error("unused lane not zero");
  AST_PAIR_ORDER: assert property (@(posedge core_clk) disable iff (reset) // R12
    load && lane2x |=> st_reg.bank[5] == {$past(word[6]), $past(word[7])})
    else $error("shared lane order wrong");
  AST_AVG_LANE: assert property (@(posedge core_clk) disable iff (reset) // R2
    load && avg_sel && pat == ADOP_PAT_NONE
    |=> st_reg.bank[2][26:14] == $past(avg_word[0][12:0]) && st_reg.bank[0] == 28'h0000000)
    else $error("average lane wrong");
  AST_CODING_MSB: assert property (@(posedge core_clk) disable iff (reset) // R3
    load && !lane2x && !avg_sel && pat == ADOP_PAT_NONE
    |=> st_reg.bank[0][27] == ($past(proc[0][13]) ^ $past(obin)))
    else $error("output coding msb wrong");
  AST_LINK_LEN: assert property (@(posedge lane_bit_clock) disable iff (reset) // R11
    lk_reg.start |-> lk_reg.count == (lk_reg.two_x ? `ADOP_PAIRS_2X : `ADOP_PAIRS_1X))
    else $error("frame length wrong");
  AST_LINK_COUNT: assert property (@(posedge lane_bit_clock) disable iff (reset) // R10
    lk_reg.count != 4'h0 |=> lk_reg.count == $past(lk_reg.count) - 4'h1)
    else $error("bit pair count did not step");
  AST_ONES: assert property (@(posedge core_clk) disable iff (reset) // R18
    load && pat == ADOP_PAT_ONES && !lane2x |=> st_reg.bank[3][27:14] == `ADOP_ONES_WORD)
    else $error("ones pattern wrong");
  AST_CUSTOM_LANE: assert property (@(posedge core_clk) disable iff (reset) // R22
    load && pat == ADOP_PAT_CUSTOM && !lane2x
    |=> st_reg.bank[4][27:14] == $past(st_reg.custom_pattern_value[`ADOP_CUSTOM_HI:0]))
    else $error("custom pattern wrong");
  AST_TOGGLE_LANE: assert property (@(posedge core_clk) disable iff (reset) // R21
    load && pat == ADOP_PAT_TOGGLE && !lane2x
    |=> st_reg.bank[2][27:14] == {14{$past(st_reg.toggle)}})
    else $error("toggle pattern wrong");
  AST_TOGGLE_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R21
    adc_sample_valid && !ramp_clear |=> st_reg.toggle != $past(st_reg.toggle))
    else $error("toggle did not flip");
  AST_CHOP_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R9
    adc_sample_valid |=> st_reg.chop != $past(st_reg.chop))
    else $error("chop phase did not flip");
  AST_LANE_OWN: assert property (@(posedge core_clk) disable iff (reset) // R11
    load && !lane2x && !avg_sel |=> st_reg.bank[7] == {$past(word[7]), 14'h0000})
    else $error("own lane word wrong");
  AST_AVG_ZERO: assert property (@(posedge core_clk) disable iff (reset) // R2
    load && avg_sel |=> st_reg.bank[1] == 28'h0000000 && st_reg.bank[6] == 28'h0000000)
    else $error("idle lane not zero in averaging");
  AST_RAMP_SYNC: assert property (@(posedge core_clk) disable iff (reset) // R23
    load && pat == ADOP_PAT_RAMP && !lane2x && !avg_sel &&
    st_reg.pattern_sync_control[`ADOP_BIT_PAT_SYNC] |=> st_reg.bank[0] == st_reg.bank[7])
    else $error("synced ramps differ");
  AST_BUSY_AFTER_LOAD: assert property (@(posedge core_clk) disable iff (reset) // R10
    load |=> sample_busy)
    else $error("busy not raised after load");
  AST_HOLD_BANK: assert property (@(posedge core_clk) disable iff (reset) // R10
    adc_sample_valid && !idle |=> st_reg.bank == $past(st_reg.bank))
    else $error("bank changed while link busy");
  AST_CFG_COUNT: assert property (@(posedge core_clk) disable iff (reset) // R22
    st_reg.cfg_count <= `ADOP_CFG_LAST_BIT)
    else $error("config bit count overrun");
  AST_LINK_TWO_X: assert property (@(posedge lane_bit_clock) disable iff (reset) // R12
    lk_reg.start |-> lk_reg.two_x == st_reg.bank_2x)
    else $error("frame mode mismatch");
endmodule
`default_nettype wire

// File: verif/adop_link_capture.sv
`timescale 1ns/1ns
`default_nettype none
module adop_link_capture (
  input  wire logic             lane_bit_clock,
  input  wire logic             reset,
  input  wire logic             two_x,
  input  wire logic [7:0]       lane_rise_bits,
  input  wire logic [7:0]       lane_fall_bits,
  input  wire logic             lane_word_start,
  output logic      [7:0][27:0] words,
  output logic      [15:0]      word_count
);
  logic [7:0][27:0] shift;
  int               pairs;
  always @(posedge lane_bit_clock or posedge reset) begin
    if (reset) begin
      shift = '0;
      pairs = 0;
      words <= '0;
      word_count <= '0;
    end else if (lane_word_start || pairs > 0) begin
      if (lane_word_start) begin
        shift = '0;
        pairs = 0;
      end
      for (int l = 0; l < 8; l++) begin
        shift[l] = {shift[l][25:0], lane_rise_bits[l], lane_fall_bits[l]};
      end
      pairs = pairs + 1;
      if (pairs == (two_x ? 14 : 7)) begin
        words <= shift;
        word_count <= word_count + 16'h0001;
        pairs = 0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/test_adc_digital_output_processing.sv
`timescale 1ns/1ns
`default_nettype none
`include "adop_regs.svh"
module test_adc_digital_output_processing;
  import adop_pkg::*;
  logic             core_clk, reset, lane_bit_clock, adc_sample_valid, two_x;
  logic [7:0][13:0] adc_sample_data;
  logic             cfg_sclk, cfg_sen_n, cfg_sdata, sample_busy, noise_chop_phase;
  logic [7:0]       lane_rise_bits, lane_fall_bits;
  logic             lane_word_start;
  logic [7:0][27:0] words;
  logic [15:0]      word_count;
  int               err_total, total_checks, k, s;
  int               x [8], off [8], gc [8], hx [8], hy [8];
  bit               coding, offs_en, gain_en, hpf_lo;
  logic [13:0]      r, cust;
  logic [13:0]      pw [5];
  localparam logic [7:0] CH_ADDR [8] = '{`ADOP_ADDR_CH1, `ADOP_ADDR_CH2, `ADOP_ADDR_CH3,
    `ADOP_ADDR_CH4, `ADOP_ADDR_CH5, `ADOP_ADDR_CH6, `ADOP_ADDR_CH7, `ADOP_ADDR_CH8};
  localparam adop_pattern_t PC [5] = '{ADOP_PAT_SYNC, ADOP_PAT_DESKEW, ADOP_PAT_ONES,
    ADOP_PAT_ZEROS, ADOP_PAT_CUSTOM};
  adop_core adop_core_inst (.core_clk(core_clk), .reset(reset), .lane_bit_clock(lane_bit_clock),
    .adc_sample_valid(adc_sample_valid), .adc_sample_data(adc_sample_data), .cfg_sclk(cfg_sclk),
    .cfg_sen_n(cfg_sen_n), .cfg_sdata(cfg_sdata), .sample_busy(sample_busy),
    .noise_chop_phase(noise_chop_phase), .lane_rise_bits(lane_rise_bits),
    .lane_fall_bits(lane_fall_bits), .lane_word_start(lane_word_start));
  adop_link_capture adop_link_capture_inst (.lane_bit_clock(lane_bit_clock), .reset(reset),
    .two_x(two_x), .lane_rise_bits(lane_rise_bits), .lane_fall_bits(lane_fall_bits),
    .lane_word_start(lane_word_start), .words(words), .word_count(word_count));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    lane_bit_clock = 1'b0;
    #7;
    forever #15 lane_bit_clock = ~lane_bit_clock;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [27:0] got, input logic [27:0] exp, input int tol,
                     input string what);
    int d;
    d = int'($signed(got[13:0] ^ {coding, 13'h0000})) -
        int'($signed(exp[13:0] ^ {coding, 13'h0000}));
    total_checks++;
    if (!(got === exp || (!$isunknown(got) && got[27:14] === exp[27:14] && d <= tol
        && d >= -tol))) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    cyc(6);
    reset <= 1'b0;
    cyc(4);
    {coding, offs_en, gain_en, hpf_lo, two_x} = '0;
  endtask
  task automatic cfg_write(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] frame;
    frame = {addr, data};
    cfg_sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      cyc(1);
      cfg_sdata <= frame[i];
      cyc(3);
      cfg_sclk <= 1'b1;
      cyc(3);
      cfg_sclk <= 1'b0;
    end
    cyc(3);
    cfg_sen_n <= 1'b1;
    cyc(6);
  endtask
  task automatic rand_x(input int lim);
    for (int c = 0; c < 8; c++) x[c] = int'($urandom_range(2 * lim)) - lim;
  endtask
  task automatic send();
    logic [15:0] cnt0;
    int          n;
    n = 0;
    while (sample_busy !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n == 100) begin
      err_total++;
      $display("CHECK FAILED at %0t: busy stuck", $time);
    end
    for (int c = 0; c < 8; c++) adc_sample_data[c] <= x[c][13:0];
    adc_sample_valid <= 1'b1;
    cnt0 = word_count;
    cyc(1);
    adc_sample_valid <= 1'b0;
    n = 0;
    while (word_count === cnt0 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n == 200) begin
      err_total++;
      $display("CHECK FAILED at %0t: no word", $time);
    end
    cyc(2);
  endtask
  function automatic int sat(input int v);
    return v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
  endfunction
  function automatic int proc(input int c);
    int v;
    v = x[c] - (offs_en ? off[c] : 0);
    if (hpf_lo && c < 4) begin
      hy[c] = (v - hx[c] + hy[c]) * (1 << k) / ((1 << k) + 1);
      hx[c] = v;
      v = hy[c];
    end
    if (gain_en) v = int'(real'(sat(v)) * 10.0 ** (0.01 * (gc[c] > 30 ? 30 : gc[c])));
    return sat(v);
  endfunction
  function automatic logic [27:0] w14(input int v);
    return {14'h0000, 14'(v) ^ (coding ? 14'h2000 : 14'h0000)};
  endfunction
  task automatic check_model(input int tol);
    for (int c = 0; c < 8; c++) chk(words[c], w14(proc(c)), tol, "data");
  endtask
  initial begin
    #1000000;
    err_total++;
    $display("CHECK FAILED at %0t: timeout", $time);
    end_sim();
  end
  initial begin
    reset = 1'b1;
    {adc_sample_valid, cfg_sclk, cfg_sdata, two_x} = '0;
    cfg_sen_n = 1'b1;
    adc_sample_data = '0;
    void'($urandom(82281));
    do_reset();
    for (int m = 0; m < 2; m++) begin
      coding = m[0];
      cfg_write(`ADOP_ADDR_CODING, m[0] ? 16'h0008 : 16'h0000);
      repeat (3) begin
        rand_x(8191);
        send();
        check_model(0);
      end
    end
    offs_en = 1'b1;
    gain_en = 1'b1;
    for (int c = 0; c < 8; c++) begin
      off[c] = int'($urandom_range(1023)) - 512;
      gc[c] = c < 2 ? 31 - c : int'($urandom_range(31));
      cfg_write(CH_ADDR[c], {5'(gc[c]), 1'b0, 10'(off[c])});
    end
    cfg_write(`ADOP_ADDR_OFFS_GAIN, 16'h1100);
    repeat (3) begin
      rand_x(2000);
      send();
      check_model(4);
    end
    do_reset();
    k = 2;
    hpf_lo = 1'b1;
    hx = '{default: 0};
    hy = '{default: 0};
    cfg_write(`ADOP_ADDR_HPF_LO, 16'h0005);
    x = '{default: 1000};
    repeat (8) begin
      send();
      check_model(0);
    end
    do_reset();
    cfg_write(`ADOP_ADDR_NOISE_LANE, 16'h0800);
    x = '{default: 500};
    s = 500;
    repeat (4) begin
      chk({27'h0, noise_chop_phase}, {27'h0, s < 0}, 0, "phase");
      send();
      for (int c = 0; c < 8; c++) chk(words[c], w14(s), 0, "chop");
      s = -s;
    end
    do_reset();
    cfg_write(`ADOP_ADDR_AVG_PAT, 16'h0800);
    repeat (3) begin
      rand_x(8191);
      send();
      for (int c = 0; c < 8; c++) chk(words[c], (c < 2 || c > 5) ? 28'h0 :
        w14((x[2 * c - 4] + x[2 * c - 3]) >>> 1), 0, "avg");
    end
    do_reset();
    two_x = 1'b1;
    cfg_write(`ADOP_ADDR_NOISE_LANE, 16'h4000);
    repeat (3) begin
      rand_x(8191);
      send();
      for (int c = 0; c < 8; c++) chk(words[c], (c < 2 || c > 5) ? 28'h0 :
        {x[2 * c - 4][13:0], x[2 * c - 3][13:0]}, 0, "lane2x");
    end
    do_reset();
    cust = 14'($urandom);
    cfg_write(`ADOP_ADDR_CUSTOM, {2'b00, cust});
    pw = '{14'h3f80, 14'h1555, 14'h3fff, 14'h0000, cust};
    for (int i = 0; i < 5; i++) begin
      cfg_write(`ADOP_ADDR_AVG_PAT, {PC[i], 13'h0000});
      send();
      for (int c = 0; c < 8; c++) chk(words[c], {14'h0, pw[i]}, 0, "pat");
    end
    cust = ~cust;
    cfg_write(`ADOP_ADDR_CUSTOM, {2'b00, cust});
    send();
    for (int c = 0; c < 8; c++) chk(words[c], {14'h0, cust}, 0, "custom");
    cfg_write(`ADOP_ADDR_AVG_PAT, {ADOP_PAT_TOGGLE, 13'h0000});
    send();
    r = words[0][13] ? 14'h3fff : 14'h0000;
    repeat (3) begin
      for (int c = 0; c < 8; c++) chk(words[c], {14'h0, r}, 0, "toggle");
      r = ~r;
      send();
    end
    cfg_write(`ADOP_ADDR_PAT_SYNC, 16'h0100);
    cfg_write(`ADOP_ADDR_AVG_PAT, {ADOP_PAT_RAMP, 13'h0000});
    send();
    r = 14'h0000;
    repeat (4) begin
      for (int c = 0; c < 8; c++) chk(words[c], {14'h0, r}, 0, "ramp");
      r = r + 14'h0001;
      send();
    end
    end_sim();
  end
endmodule
`default_nettype wire
